// ===== src/sfc_pkg.sv
// constants shared by the frame and select control block
`default_nettype none

package sfc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 26;                 // byte address width
    localparam int DATA_W = 32;                 // bus data width
    localparam int REG_W  = 8;                  // register width

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_FRAME_CMD  = 26'h0FF_E261;
    localparam logic [ADDR_W-1:0] IDX_SERIAL_CTL = 26'h0FF_E262;
    localparam logic [ADDR_W-1:0] IDX_SEL_SETUP  = 26'h0FF_E263;
    localparam logic [ADDR_W-1:0] IDX_SEL_STATUS = 26'h0FF_E264;
    localparam logic [ADDR_W-1:0] ADDR_FRAME_CMD  = IDX_FRAME_CMD << 2;
    localparam logic [ADDR_W-1:0] ADDR_SERIAL_CTL = IDX_SERIAL_CTL << 2;
    localparam logic [ADDR_W-1:0] ADDR_SEL_SETUP  = IDX_SEL_SETUP << 2;
    localparam logic [ADDR_W-1:0] ADDR_SEL_STATUS = IDX_SEL_STATUS << 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_FRAME_CMD  = 8'h00;
    localparam logic [REG_W-1:0] RST_SERIAL_CTL = 8'h00;
    localparam logic [REG_W-1:0] RST_SEL_SETUP  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FC_SEL_VALUE   = 0;          // select_value_bit
    localparam int FC_FRAME_END   = 1;          // frame_end_flag
    localparam int FC_RSVD_LO     = 2;          // reserved 7:2
    localparam int CTL_PORT_EN_LO = 0;          // port_enable_low
    localparam int CTL_MASTER     = 1;          // master_role_enable
    localparam int CTL_WIRED_OR   = 2;
    localparam int CTL_CLK_POL    = 3;          // clock_polarity_bit
    localparam int CTL_PHASE      = 4;
    localparam int CTL_BAUD_TIMER = 5;          // baud_timer_control
    localparam int CTL_PORT_EN_HI = 6;          // port_enable_high
    localparam int CTL_DATA_IRQ   = 7;          // data_interrupt_enable
    localparam int SU_PIN_DIR     = 0;          // select_pin_direction
    localparam int ST_PIN_LEVEL   = 0;          // status: pin level
    localparam int ST_DRIVING     = 1;          // status: pin driven
    localparam int ST_CHAR_BUSY   = 2;          // status: char shifting

    // ------------------------------------------------------------
    // character timing and bus answers
    // ------------------------------------------------------------
    localparam logic [3:0] CHAR_LAST_EDGE = 4'h7; // eighth edge ends char
    localparam logic [3:0] EDGE_CNT_ZERO  = 4'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire

// ===== src/sfc_sync2.sv
// two-flop synchroniser for a level from outside the clock domain
`default_nettype none

module sfc_sync2
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output var  logic syncOut
);

    // ------------------------------------------------------------
    // stages; the first is read by the second only
    // ------------------------------------------------------------
    logic stage1_reg;                           // metastable catch
    logic stage2_reg;                           // settled copy

    // both stages clear on reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

    // ------------------------------------------------------------
    // check: output follows input after two edges
    // ------------------------------------------------------------
    property p_sync_delay;
        @(posedge sys_clk) disable iff (rst)
        $rose(syncOut) |-> $past(asyncIn, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchroniser output rose without input");

endmodule

`default_nettype wire

// ===== src/sfc_top.sv
// frame end and select pin control with its register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none

module sfc_top
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // axi4-lite slave
    input  wire logic [sfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [sfc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [sfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [sfc_pkg::DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // dma transmit side, same clock
    input  wire logic                       dmaFirstByte,
    input  wire logic                       dmaSelValue,
    input  wire logic                       dmaFrameEnd,
    output var  logic                       txFrameDoneToDma,
    // shift engine start strobe, same clock
    input  wire logic                       charStart,
    // serial link
    input  wire logic                       linkSck,
    output var  logic                       selPinOut,
    output var  logic                       selPinOe_n
);
    import sfc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic              selValue_reg;            // select_value_bit
    logic              selValue_next;
    logic              frameEnd_reg;            // frame_end_flag
    logic              frameEnd_next;
    logic [REG_W-1:0]  serialCtl_reg;           // serial_control
    logic              pinDir_reg;              // select_pin_direction
    logic              charBusy_reg;            // character shifting
    logic [3:0]        edgeCnt_reg;             // link edges counted
    logic              sckPrev_reg;             // last synced sck
    logic              awReady_reg;             // write addr slot free
    logic              wReady_reg;              // write data slot free
    logic [ADDR_W-1:0] awAddr_reg;              // held write address
    logic [REG_W-1:0]  wData_reg;               // held write byte
    logic              wLane0_reg;              // low lane strobe
    logic              bValid_reg;
    logic [1:0]        bResp_reg;
    logic              arReady_reg;
    logic              rValid_reg;
    logic [DATA_W-1:0] rData_reg;
    logic [1:0]        rResp_reg;
    logic              pinOut_reg;
    logic              pinOe_n_reg;
    logic              frameDone_reg;

    // ------------------------------------------------------------
    // link clock sampling and edge finding
    // ------------------------------------------------------------
    logic sckSync;                              // settled link clock

    sfc_sync2 u_sck_sync
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (linkSck),
        .syncOut (sckSync)
    );

    // trailing edge depends on polarity: idle low ends on a fall
    wire clock_polarity_bit    = serialCtl_reg[CTL_CLK_POL];
    wire sckEdge   = clock_polarity_bit ? (sckSync & ~sckPrev_reg)
                            : (~sckSync & sckPrev_reg);
    wire charDone  = charBusy_reg & sckEdge
                   & (edgeCnt_reg == CHAR_LAST_EDGE);
    wire frameOver = charDone & frameEnd_reg;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire writeGo    = ~awReady_reg & ~wReady_reg & ~bValid_reg;
    wire wrFrameCmd = writeGo & wLane0_reg
                    & (awAddr_reg == ADDR_FRAME_CMD);
    wire wrCtl      = writeGo & wLane0_reg
                    & (awAddr_reg == ADDR_SERIAL_CTL);
    wire wrSetup    = writeGo & wLane0_reg
                    & (awAddr_reg == ADDR_SEL_SETUP);
    wire wrMapped   = (awAddr_reg == ADDR_FRAME_CMD)
                    | (awAddr_reg == ADDR_SERIAL_CTL)
                    | (awAddr_reg == ADDR_SEL_SETUP)
                    | (awAddr_reg == ADDR_SEL_STATUS);
    wire arTake     = s_axi_arvalid & arReady_reg;
    wire masterOn   = serialCtl_reg[CTL_MASTER];
    wire driveSel   = masterOn & pinDir_reg;

    // upper command bits are reserved and read zero
    wire [REG_W-1:0] frameCmdView = {{(REG_W-FC_RSVD_LO){1'b0}},
                                     frameEnd_reg, selValue_reg};
    wire [REG_W-1:0] statusView   = {5'h00, charBusy_reg, driveSel,
                                     pinOut_reg};
    wire [REG_W-1:0] readByte =
        (s_axi_araddr == ADDR_FRAME_CMD)  ? frameCmdView  :
        (s_axi_araddr == ADDR_SERIAL_CTL) ? serialCtl_reg :
        (s_axi_araddr == ADDR_SEL_SETUP)  ? {7'h00, pinDir_reg} :
        (s_axi_araddr == ADDR_SEL_STATUS) ? statusView : 8'h00;
    wire rdMapped = (s_axi_araddr == ADDR_FRAME_CMD)
                  | (s_axi_araddr == ADDR_SERIAL_CTL)
                  | (s_axi_araddr == ADDR_SEL_SETUP)
                  | (s_axi_araddr == ADDR_SEL_STATUS);

    // ------------------------------------------------------------
    // frame flag and select value: later sources win
    // ------------------------------------------------------------
    // order: frame end clear, bus write, then dma set, so a
    // hardware set is never lost to a clear in the same cycle
    always_comb
    begin
        selValue_next = selValue_reg;
        frameEnd_next = frameEnd_reg;
        if (frameOver)
        begin
            selValue_next = ~selValue_reg;
            frameEnd_next = 1'b0;
        end
        if (wrFrameCmd)
        begin
            selValue_next = wData_reg[FC_SEL_VALUE];
            frameEnd_next = wData_reg[FC_FRAME_END];
        end
        if (dmaFirstByte)
        begin
            selValue_next = dmaSelValue;
        end
        if (dmaFrameEnd)
        begin
            frameEnd_next = 1'b1;
        end
    end

    // flag and value storage
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            selValue_reg <= RST_FRAME_CMD[FC_SEL_VALUE];
            frameEnd_reg <= RST_FRAME_CMD[FC_FRAME_END];
        end
        else
        begin
            selValue_reg <= selValue_next;
            frameEnd_reg <= frameEnd_next;
        end
    end

    // ------------------------------------------------------------
    // control and setup registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            serialCtl_reg <= RST_SERIAL_CTL;
            pinDir_reg    <= RST_SEL_SETUP[SU_PIN_DIR];
        end
        else
        begin
            if (wrCtl)
                serialCtl_reg <= wData_reg;
            if (wrSetup)
                pinDir_reg <= wData_reg[SU_PIN_DIR];
        end
    end

    // ------------------------------------------------------------
    // character tracker on link clock edges
    // ------------------------------------------------------------
    // limitation: a start strobe during a character restarts count
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sckPrev_reg  <= 1'b0;
            charBusy_reg <= 1'b0;
            edgeCnt_reg  <= EDGE_CNT_ZERO;
        end
        else
        begin
            sckPrev_reg <= sckSync;
            if (charStart)
            begin
                charBusy_reg <= 1'b1;
                edgeCnt_reg  <= EDGE_CNT_ZERO;
            end
            else if (charDone)
                charBusy_reg <= 1'b0;
            else if (charBusy_reg && sckEdge)
                edgeCnt_reg <= edgeCnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // pin and dma outputs
    // ------------------------------------------------------------
    // pin copies the next value so it moves with the register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pinOut_reg    <= 1'b1;
            pinOe_n_reg   <= 1'b1;
            frameDone_reg <= 1'b0;
        end
        else
        begin
            pinOut_reg    <= selValue_next;
            pinOe_n_reg   <= ~driveSel;
            frameDone_reg <= frameOver;
        end
    end

    assign selPinOut        = pinOut_reg;
    assign selPinOe_n       = pinOe_n_reg;
    assign txFrameDoneToDma = frameDone_reg;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            awReady_reg <= 1'b1;
            wReady_reg  <= 1'b1;
            awAddr_reg  <= '0;
            wData_reg   <= '0;
            wLane0_reg  <= 1'b0;
            bValid_reg  <= 1'b0;
            bResp_reg   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && awReady_reg)
            begin
                awReady_reg <= 1'b0;
                awAddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wReady_reg)
            begin
                wReady_reg <= 1'b0;
                wData_reg  <= s_axi_wdata[REG_W-1:0];
                wLane0_reg <= s_axi_wstrb[0];
            end
            if (writeGo)
            begin
                bValid_reg <= 1'b1;
                bResp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bValid_reg && s_axi_bready)
            begin
                bValid_reg  <= 1'b0;
                awReady_reg <= 1'b1;
                wReady_reg  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            arReady_reg <= 1'b1;
            rValid_reg  <= 1'b0;
            rData_reg   <= DATA_ZERO;
            rResp_reg   <= RESP_OKAY;
        end
        else if (arTake)
        begin
            arReady_reg <= 1'b0;
            rValid_reg  <= 1'b1;
            rData_reg   <= {24'h00_0000, readByte};
            rResp_reg   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rValid_reg && s_axi_rready)
        begin
            rValid_reg  <= 1'b0;
            arReady_reg <= 1'b1;
        end
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready  = wReady_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire quiet = ~wrFrameCmd & ~dmaFirstByte & ~dmaFrameEnd;

    property p_frame_toggle;
        @(posedge sys_clk) disable iff (rst)
        frameOver && quiet |=> selValue_reg != $past(selValue_reg)
                               && !frameEnd_reg;
    endproperty
    a_frame_toggle: assert property (p_frame_toggle)
        else $error("select did not toggle at frame end");

    property p_hold_no_end;
        @(posedge sys_clk) disable iff (rst)
        charDone && !frameEnd_reg && quiet |=> $stable(selValue_reg);
    endproperty
    a_hold_no_end: assert property (p_hold_no_end)
        else $error("select changed without frame end");

    property p_pin_follows;
        @(posedge sys_clk) disable iff (rst)
        driveSel ##1 $stable(selValue_reg) |->
            selPinOut == selValue_reg && !selPinOe_n;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("select pin does not show select value");

    property p_pin_released;
        @(posedge sys_clk) disable iff (rst)
        !masterOn |=> selPinOe_n;
    endproperty
    a_pin_released: assert property (p_pin_released)
        else $error("select pin driven outside master mode");

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (rst)
        arTake && s_axi_araddr == ADDR_FRAME_CMD |=>
            s_axi_rvalid && s_axi_rdata[REG_W-1:FC_RSVD_LO] == 6'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved command bits read non zero");

    property p_dma_end;
        @(posedge sys_clk) disable iff (rst)
        dmaFrameEnd |=> frameEnd_reg;
    endproperty
    a_dma_end: assert property (p_dma_end)
        else $error("dma end strobe did not set frame flag");

    property p_dma_first;
        @(posedge sys_clk) disable iff (rst)
        dmaFirstByte |=> selValue_reg == $past(dmaSelValue);
    endproperty
    a_dma_first: assert property (p_dma_first)
        else $error("descriptor select value not loaded");

    property p_done_pulse;
        @(posedge sys_clk) disable iff (rst)
        frameOver |=> txFrameDoneToDma ##1 !txFrameDoneToDma;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("frame done pulse missing or too long");

    property p_bus_write;
        @(posedge sys_clk) disable iff (rst)
        wrFrameCmd && !dmaFirstByte && !dmaFrameEnd |=>
            frameEnd_reg == $past(wData_reg[FC_FRAME_END])
            && selValue_reg == $past(wData_reg[FC_SEL_VALUE]);
    endproperty
    a_bus_write: assert property (p_bus_write)
        else $error("bus write to command register lost");

    property p_ctl_reset;
        @(posedge sys_clk)
        rst |=> serialCtl_reg == RST_SERIAL_CTL && !frameEnd_reg;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("control register not cleared by reset");

    c_frame_end: cover property (@(posedge sys_clk) disable iff (rst)
        frameOver);
    c_char_plain: cover property (@(posedge sys_clk) disable iff (rst)
        charDone && !frameEnd_reg);
    c_write_resp: cover property (@(posedge sys_clk) disable iff (rst)
        s_axi_bvalid && s_axi_bready);
    c_dma_clash: cover property (@(posedge sys_clk) disable iff (rst)
        frameOver && dmaFrameEnd);

endmodule

`default_nettype wire

// ===== verification/sfc_link_model.sv
// far-side serial clock source that shifts one character per request
`default_nettype none

module sfc_link_model
(
    input  wire logic go,
    output var  logic linkSck
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // eight clock periods of 160 ns, idle low between characters
    // ------------------------------------------------------------
    initial linkSck = 1'b0;             // stands still outside frames

    // falling edges are the trailing edges when polarity is zero
    always @(posedge go)
    begin
        #5;                             // keep link edges off clock edges
        repeat (8)
        begin
            #80 linkSck = 1'b1;
            #80 linkSck = 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== verification/sfc_top_bench.sv
// self-checking bench for the frame and select control block
`default_nettype none

module sfc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfc_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic              sys_clk, rst, awv, wv, bRdy, arv, rRdy;
    logic              awr, wr_, bv, arr, rv, dFirst, dSel, dEnd;
    logic              done, cStart, go, sck, pin, oeN, doneSeen;
    logic [1:0]        bresp, rresp, brsp;
    logic [ADDR_W-1:0] awa, ara;
    logic [DATA_W-1:0] wdat, rd_, rdat;
    integer            err_total, num_checks, cyc;

    sfc_top sfc_top_i (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdat), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rRdy), .dmaFirstByte(dFirst),
        .dmaSelValue(dSel), .dmaFrameEnd(dEnd),
        .txFrameDoneToDma(done), .charStart(cStart), .linkSck(sck),
        .selPinOut(pin), .selPinOe_n(oeN));
    sfc_link_model sfc_link_model_i (.go(go), .linkSck(sck));

    // ------------------------------------------------------------
    // clock, watchdog and frame-done catcher
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // a hang is cut short well beyond the ~320 cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            conclude();
        end
    end
    always @(posedge sys_clk)
        if (done === 1'b1) doneSeen <= 1'b1;

    // ------------------------------------------------------------
    // bus tasks: hold each channel until its ready edge
    // ------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        integer n;
        awa <= a; wdat <= {24'h00_0000, d};
        awv <= 1'b1; wv <= 1'b1; bRdy <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n = n + 1;
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (!bv && n < 100);
        if (!bv)
            err_total = err_total + 1;
        brsp = bresp;
        bRdy <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        integer n;
        ara <= a; arv <= 1'b1; rRdy <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n = n + 1;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 100);
        if (!rv)
            err_total = err_total + 1;
        rdat = rd_;
        rRdy <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one character: start strobe, then eight link clock periods
    task automatic sendChar();
        cStart <= 1'b1;
        @(posedge sys_clk);
        cStart <= 1'b0; go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (75) @(posedge sys_clk);
    endtask
    task automatic pulse(input logic f, input logic s);
        dFirst <= f; dEnd <= ~f; dSel <= s;
        @(posedge sys_clk);
        dFirst <= 1'b0; dEnd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        err_total = 0; num_checks = 0; cyc = 0; doneSeen = 1'b0;
        rst = 1'b1; awv = 1'b0; wv = 1'b0; bRdy = 1'b0; arv = 1'b0;
        rRdy = 1'b0; awa = '0; ara = '0; wdat = '0; dFirst = 1'b0;
        dSel = 1'b0; dEnd = 1'b0; cStart = 1'b0; go = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_FRAME_CMD); chk("cmd reset", 32'h0, rdat);
        rd(ADDR_SERIAL_CTL); chk("ctl reset", 32'h0, rdat);
        wr(ADDR_SERIAL_CTL, 8'hF5);
        chk("wr okay", 32'h0, {30'h0, brsp});
        rd(ADDR_SERIAL_CTL); chk("ctl rw", 32'hF5, rdat);
        wr(ADDR_FRAME_CMD, 8'hFD);
        rd(ADDR_FRAME_CMD); chk("cmd rsvd", 32'h1, rdat);
        rd(26'h000_0010); chk("unmapped", 32'h2, {30'h0, rresp});
        wr(26'h000_0010, 8'h55);
        chk("wr unmapped", 32'h2, {30'h0, brsp});
        wr(ADDR_SERIAL_CTL, 8'h02);
        wr(ADDR_SEL_SETUP, 8'h01);
        @(posedge sys_clk);
        chk("oe_n", 32'h0, oeN);
        chk("pin high", 32'h1, pin);
        rd(ADDR_SEL_SETUP); chk("setup", 32'h1, rdat);
        rd(ADDR_SEL_STATUS); chk("status", 32'h3, rdat);
        wr(ADDR_FRAME_CMD, 8'h00);
        @(posedge sys_clk);
        chk("pin low", 32'h0, pin);
        pulse(1'b1, 1'b1);
        rd(ADDR_FRAME_CMD); chk("dma sel", 32'h1, rdat);
        sendChar();
        rd(ADDR_FRAME_CMD); chk("no end", 32'h1, rdat);
        chk("pin kept", 32'h1, pin);
        chk("no done", 32'h0, doneSeen);
        pulse(1'b0, 1'b0);
        rd(ADDR_FRAME_CMD); chk("dma end", 32'h3, rdat);
        sendChar();
        rd(ADDR_FRAME_CMD); chk("frame end", 32'h0, rdat);
        chk("pin release", 32'h0, pin);
        chk("frame done", 32'h1, doneSeen);
        // clock polarity one: rising edges end the character
        wr(ADDR_SERIAL_CTL, 8'h0A);
        pulse(1'b0, 1'b0);
        sendChar();
        rd(ADDR_FRAME_CMD); chk("rise end", 32'h1, rdat);
        chk("pin rise", 32'h1, pin);
        conclude();
    end
endmodule

`default_nettype wire
